// [rtl/dual_timer_counter.sv]
// dual 16-bit timer/counter with four modes and a plain register port
//
// Notes on behaviour
// - default time base, one tick per twelve clocks
// - turbo select gives one tick per four clocks
// - reset clears both turbo select bits
// - count pin sampled at C4, high-then-low counts
// - counts update at C3, edge counts next cycle
// - function select bits 2 and 6 choose clock/pin
// - two-bit mode field per timer
// - mode 0 is 13 bits, five-bit prescale
// - bit four falling carries; mode 0 rollover flags
// - count only with run and gate satisfied
// - mode 1 is 16 bits, flags rollover
// - mode 2 reloads low from high on overflow
// - timer b mode 3 holds its count
// - split low byte keeps timer a's controls
// - split high byte uses b's run, flag
// - split: b runs freely, mode 3 stops it
// - timer b overflow drives the baud tick
// - overflow flags request interrupt, cleared on vectoring
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps

// falling edge finder on a count pin, one event per machine cycle
module count_edge_detect (
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic at_c3,
   input  wire logic at_c4,
   input  wire logic pin,
   output logic      edge_evt
);
   logic smp_r;
   logic pend_r;

   // reset sample low so a pin low at reset makes no phantom edge
   always_ff @(posedge mclk) begin
      if (reset) begin
         smp_r  <= 1'b0;
         pend_r <= 1'b0;
      end else begin
         if (at_c4) begin
            smp_r <= pin;
         end
         if (at_c4 && smp_r && !pin) begin
            pend_r <= 1'b1;
         end else if (at_c3) begin
            pend_r <= 1'b0;
         end
      end
   end

   // C3 precedes C4, so a detected edge counts in the next machine cycle
   assign edge_evt = pend_r && at_c3;
endmodule // count_edge_detect

module dual_timer_counter (
   input  wire logic                mclk,
   input  wire logic                reset,
   input  wire timer_pkg::reg_addr_t reg_addr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [7:0]               reg_rdata,
   input  wire logic                count_input_a,
   input  wire logic                count_input_b,
   input  wire logic                ext_irq_pin_a,
   input  wire logic                ext_irq_pin_b,
   input  wire logic                vector_ack_a,
   input  wire logic                vector_ack_b,
   output logic                     timer_a_irq,
   output logic                     timer_b_irq,
   output logic                     baud_tick
);
   import timer_pkg::*;

   logic [3:0]   phase_r;
   logic [1:0]   qtr_r;
   logic         run_a_r;
   logic         run_b_r;
   logic         flag_a_r;
   logic         flag_b_r;
   logic         turbo_a_r;
   logic         turbo_b_r;
   logic         baud_r;
   logic [7:0]   rdata_r;
   timer_cfg_t   cfg_a_r;
   timer_cfg_t   cfg_b_r;
   timer_count_t cnt_a_r;
   timer_count_t cnt_b_r;
   timer_count_t cnt_a_nxt;
   timer_count_t cnt_b_nxt;
   timer_step_t  step_a;
   timer_step_t  step_b;
   logic         flag_a_nxt;
   logic         flag_b_nxt;

   // one step of a count pair in the given mode
   function automatic timer_step_t step_count(input tmode_t md, input timer_count_t c, input logic inc);
      timer_step_t s;
      s.cnt = c;
      s.ovf = 1'b0;
      if (inc) begin
         unique case (md)
            MODE_13BIT: begin
               s.cnt.lo[4:0] = c.lo[4:0] + 5'h01;
               if (c.lo[4:0] == 5'h1f) begin
                  s.cnt.hi = c.hi + 8'h01;
                  s.ovf    = (c.hi == 8'hff);
               end
            end
            MODE_16BIT: begin
               s.cnt = timer_count_t'({c.hi, c.lo} + 16'h0001);
               s.ovf = ({c.hi, c.lo} == 16'hffff);
            end
            MODE_RELOAD: begin
               s.cnt.lo = (c.lo == 8'hff) ? c.hi : c.lo + 8'h01;
               s.ovf    = (c.lo == 8'hff);
            end
            MODE_SPLIT: begin
               s.cnt.lo = c.lo + 8'h01;
               s.ovf    = (c.lo == 8'hff);
            end
         endcase
      end
      return s;
   endfunction

   // machine cycle phase and the quarter-rate divider, both free running
   always_ff @(posedge mclk) begin
      if (reset) begin
         phase_r <= 4'h0;
         qtr_r   <= 2'h0;
      end else begin
         phase_r <= (phase_r == PH_LAST) ? 4'h0 : phase_r + 4'h1;
         qtr_r   <= qtr_r + 2'h1;
      end
   end

   wire tick12 = (phase_r == PH_C3);
   wire tick4  = (qtr_r == QTR_LAST);
   wire at_c3  = (phase_r == PH_C3);
   wire at_c4  = (phase_r == PH_C4);
   wire base_a = turbo_a_r ? tick4 : tick12;
   wire base_b = turbo_b_r ? tick4 : tick12;

   logic evt_a;
   logic evt_b;

   count_edge_detect u_edge_a (
      .mclk     (mclk),
      .reset    (reset),
      .at_c3    (at_c3),
      .at_c4    (at_c4),
      .pin      (count_input_a),
      .edge_evt (evt_a)
   );

   count_edge_detect u_edge_b (
      .mclk     (mclk),
      .reset    (reset),
      .at_c3    (at_c3),
      .at_c4    (at_c4),
      .pin      (count_input_b),
      .edge_evt (evt_b)
   );

   // register decode
   wire wr_ctrl = reg_wr && (reg_addr == OFF_CTRL);
   wire wr_mode = reg_wr && (reg_addr == OFF_MODE);
   wire wr_rate = reg_wr && (reg_addr == OFF_RATE);
   wire wr_a_lo = reg_wr && (reg_addr == OFF_A_LO);
   wire wr_a_hi = reg_wr && (reg_addr == OFF_A_HI);
   wire wr_b_lo = reg_wr && (reg_addr == OFF_B_LO);
   wire wr_b_hi = reg_wr && (reg_addr == OFF_B_HI);

   // count enables; with a split, b loses its run bit to a's high byte
   wire a_split   = (cfg_a_r.mode == MODE_SPLIT);
   wire gate_ok_a = !cfg_a_r.gate || ext_irq_pin_a;
   wire gate_ok_b = !cfg_b_r.gate || ext_irq_pin_b;
   wire src_a     = cfg_a_r.ext_count ? evt_a : base_a;
   wire src_b     = cfg_b_r.ext_count ? evt_b : base_b;
   wire run_b_eff = a_split ? 1'b1 : run_b_r;
   wire inc_a     = run_a_r && gate_ok_a && src_a;
   wire inc_b     = run_b_eff && gate_ok_b && src_b && (cfg_b_r.mode != MODE_SPLIT);
   wire inc_a_hi  = a_split && run_b_r && base_a;
   wire hi_ovf_a  = inc_a_hi && (cnt_a_r.hi == 8'hff);

   assign step_a = step_count(cfg_a_r.mode, cnt_a_r, inc_a);
   assign step_b = step_count(cfg_b_r.mode, cnt_b_r, inc_b);

   // software byte writes override the same-cycle increment
   assign cnt_a_nxt.lo = wr_a_lo ? reg_wdata : step_a.cnt.lo;
   assign cnt_a_nxt.hi = wr_a_hi ? reg_wdata
                       : (a_split ? cnt_a_r.hi + {7'h00, inc_a_hi} : step_a.cnt.hi);
   assign cnt_b_nxt.lo = wr_b_lo ? reg_wdata : step_b.cnt.lo;
   assign cnt_b_nxt.hi = wr_b_hi ? reg_wdata : step_b.cnt.hi;

   // overflow set beats a clear by ack or by software in the same cycle
   wire set_a = step_a.ovf;
   wire set_b = a_split ? hi_ovf_a : step_b.ovf;
   assign flag_a_nxt = wr_ctrl ? (reg_wdata[CTRL_FLAG_A] | set_a)
                               : (set_a | (flag_a_r & !vector_ack_a));
   assign flag_b_nxt = wr_ctrl ? (reg_wdata[CTRL_FLAG_B] | set_b)
                               : (set_b | (flag_b_r & !vector_ack_b));

   // read selection; unmapped offsets read zero
   wire [7:0] ctrl_val = {flag_b_r, run_b_r, flag_a_r, run_a_r, 4'h0};
   wire [7:0] rate_val = {6'h00, turbo_b_r, turbo_a_r};
   wire [7:0] rd_val   = (reg_addr == OFF_CTRL) ? ctrl_val
                       : (reg_addr == OFF_MODE) ? {cfg_b_r, cfg_a_r}
                       : (reg_addr == OFF_RATE) ? rate_val
                       : (reg_addr == OFF_A_LO) ? cnt_a_r.lo
                       : (reg_addr == OFF_A_HI) ? cnt_a_r.hi
                       : (reg_addr == OFF_B_LO) ? cnt_b_r.lo
                       : (reg_addr == OFF_B_HI) ? cnt_b_r.hi
                       : 8'h00;

   // control and configuration registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         run_a_r   <= 1'b0;
         run_b_r   <= 1'b0;
         cfg_a_r   <= timer_cfg_t'(RST_CFG);
         cfg_b_r   <= timer_cfg_t'(RST_CFG);
         turbo_a_r <= 1'b0;
         turbo_b_r <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            run_a_r <= reg_wdata[CTRL_RUN_A];
            run_b_r <= reg_wdata[CTRL_RUN_B];
         end
         if (wr_mode) begin
            cfg_a_r <= timer_cfg_t'(reg_wdata[3:0]);
            cfg_b_r <= timer_cfg_t'(reg_wdata[7:4]);
         end
         if (wr_rate) begin
            turbo_a_r <= reg_wdata[RATE_TURBO_A];
            turbo_b_r <= reg_wdata[RATE_TURBO_B];
         end
      end
   end

   // counts, flags, baud tick and read data
   always_ff @(posedge mclk) begin
      if (reset) begin
         cnt_a_r  <= timer_count_t'({RST_BYTE, RST_BYTE});
         cnt_b_r  <= timer_count_t'({RST_BYTE, RST_BYTE});
         flag_a_r <= 1'b0;
         flag_b_r <= 1'b0;
         baud_r   <= 1'b0;
         rdata_r  <= 8'h00;
      end else begin
         cnt_a_r  <= cnt_a_nxt;
         cnt_b_r  <= cnt_b_nxt;
         flag_a_r <= flag_a_nxt;
         flag_b_r <= flag_b_nxt;
         baud_r   <= step_b.ovf;
         rdata_r  <= reg_rd ? rd_val : 8'h00;
      end
   end

   assign reg_rdata   = rdata_r;
   assign timer_a_irq = flag_a_r;
   assign timer_b_irq = flag_b_r;
   assign baud_tick   = baud_r;

   // checks
   property p_turbo_reset;
      @(posedge mclk) disable iff (reset) $fell(reset) |-> (!turbo_a_r && !turbo_b_r);
   endproperty
   a_turbo_reset: assert property (p_turbo_reset) else $error("turbo bits not clear after reset");

   property p_slow_tick;
      @(posedge mclk) disable iff (reset) tick12 |-> ##12 tick12 ##1 !tick12 [*8];
   endproperty
   a_slow_tick: assert property (p_slow_tick) else $error("base tick not every twelve clocks");

   property p_fast_tick;
      @(posedge mclk) disable iff (reset) tick4 |-> ##1 !tick4 [*3] ##1 tick4;
   endproperty
   a_fast_tick: assert property (p_fast_tick) else $error("turbo tick not every four clocks");

   property p_edge_at_c3;
      @(posedge mclk) disable iff (reset) evt_a |-> (phase_r == PH_C3) && !$past(count_input_a, 11);
   endproperty
   a_edge_at_c3: assert property (p_edge_at_c3) else $error("pin count outside C3 or without low sample");

   property p_run_hold;
      @(posedge mclk) disable iff (reset)
         (!run_a_r && !a_split && !wr_a_lo && !wr_a_hi) |=> (cnt_a_r == $past(cnt_a_r));
   endproperty
   a_run_hold: assert property (p_run_hold) else $error("timer a counted while stopped");

   property p_mode1_ovf;
      @(posedge mclk) disable iff (reset)
         (inc_a && cfg_a_r.mode == MODE_16BIT && cnt_a_r == 16'hffff && !wr_a_lo && !wr_a_hi)
         |=> flag_a_r && cnt_a_r == 16'h0000;
   endproperty
   a_mode1_ovf: assert property (p_mode1_ovf) else $error("16-bit rollover lost");

   property p_reload;
      @(posedge mclk) disable iff (reset)
         (inc_a && cfg_a_r.mode == MODE_RELOAD && cnt_a_r.lo == 8'hff && !wr_a_lo && !wr_a_hi)
         |=> cnt_a_r.lo == $past(cnt_a_r.hi) && cnt_a_r.hi == $past(cnt_a_r.hi) && flag_a_r;
   endproperty
   a_reload: assert property (p_reload) else $error("reload from high byte failed");

   property p_b_frozen;
      @(posedge mclk) disable iff (reset)
         (cfg_b_r.mode == MODE_SPLIT && !wr_b_lo && !wr_b_hi) |=> (cnt_b_r == $past(cnt_b_r));
   endproperty
   a_b_frozen: assert property (p_b_frozen) else $error("timer b moved in mode 3");

   property p_ack_clear;
      @(posedge mclk) disable iff (reset) (vector_ack_a && !set_a && !wr_ctrl) |=> !timer_a_irq;
   endproperty
   a_ack_clear: assert property (p_ack_clear) else $error("flag a not cleared on vectoring");

   property p_sw_wins;
      @(posedge mclk) disable iff (reset) wr_a_lo |=> cnt_a_r.lo == $past(reg_wdata);
   endproperty
   a_sw_wins: assert property (p_sw_wins) else $error("software low byte write lost");

   property p_sw_wins_hi;
      @(posedge mclk) disable iff (reset) wr_a_hi |=> cnt_a_r.hi == $past(reg_wdata);
   endproperty
   a_sw_wins_hi: assert property (p_sw_wins_hi) else $error("software high byte write lost");

   property p_mode0_carry;
      @(posedge mclk) disable iff (reset)
         (inc_a && cfg_a_r.mode == MODE_13BIT && cnt_a_r.lo[4:0] == 5'h1f && !wr_a_lo && !wr_a_hi)
         |=> cnt_a_r.hi == $past(cnt_a_r.hi) + 8'h01 && cnt_a_r.lo[7:5] == $past(cnt_a_r.lo[7:5]);
   endproperty
   a_mode0_carry: assert property (p_mode0_carry) else $error("mode 0 carry into high byte lost");

   property p_gate_hold;
      @(posedge mclk) disable iff (reset)
         (cfg_a_r.gate && !ext_irq_pin_a && !a_split && !wr_a_lo && !wr_a_hi) |=> (cnt_a_r == $past(cnt_a_r));
   endproperty
   a_gate_hold: assert property (p_gate_hold) else $error("timer a counted with gate closed");

   // split mode: a's high byte borrows b's run bit and flag, b keeps counting
   property p_split_lo;
      @(posedge mclk) disable iff (reset)
         (a_split && !run_a_r && !wr_a_lo) |=> (cnt_a_r.lo == $past(cnt_a_r.lo));
   endproperty
   a_split_lo: assert property (p_split_lo) else $error("split low byte ran without run bit");

   property p_split_hi;
      @(posedge mclk) disable iff (reset)
         (inc_a_hi && !wr_a_hi) |=> cnt_a_r.hi == $past(cnt_a_r.hi) + 8'h01;
   endproperty
   a_split_hi: assert property (p_split_hi) else $error("split high byte did not step");

   property p_split_flag;
      @(posedge mclk) disable iff (reset) hi_ovf_a |=> timer_b_irq;
   endproperty
   a_split_flag: assert property (p_split_flag) else $error("split high byte rollover missed flag b");

   property p_b_no_flag;
      @(posedge mclk) disable iff (reset)
         (a_split && step_b.ovf && !hi_ovf_a && !flag_b_r && !wr_ctrl) |=> !timer_b_irq;
   endproperty
   a_b_no_flag: assert property (p_b_no_flag) else $error("timer b overflow set flag b during split");

   property p_b_runs_split;
      @(posedge mclk) disable iff (reset)
         (a_split && src_b && !cfg_b_r.gate && cfg_b_r.mode == MODE_RELOAD && !wr_b_lo)
         |=> baud_tick || cnt_b_r.lo == $past(cnt_b_r.lo) + 8'h01;
   endproperty
   a_b_runs_split: assert property (p_b_runs_split) else $error("timer b stalled during split");

   property p_baud;
      @(posedge mclk) disable iff (reset) step_b.ovf |=> baud_tick;
   endproperty
   a_baud: assert property (p_baud) else $error("timer b overflow gave no baud tick");

endmodule // dual_timer_counter

// [include/timer_pkg.sv]
// shared constants and types for the dual timer/counter
package timer_pkg;

   // operating modes of one timer
   typedef enum logic [1:0] {
      MODE_13BIT,
      MODE_16BIT,
      MODE_RELOAD,
      MODE_SPLIT
   } tmode_t;

   // per-timer nibble of the mode register
   typedef struct packed {
      logic   gate;
      logic   ext_count;
      tmode_t mode;
   } timer_cfg_t;

   // one timer's count pair
   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } timer_count_t;

   // count pair after one step, with rollover
   typedef struct packed {
      logic         ovf;
      timer_count_t cnt;
   } timer_step_t;

   typedef logic [2:0] reg_addr_t;

   // register offsets
   localparam reg_addr_t OFF_CTRL = 3'h0;
   localparam reg_addr_t OFF_MODE = 3'h1;
   localparam reg_addr_t OFF_RATE = 3'h2;
   localparam reg_addr_t OFF_A_LO = 3'h3;
   localparam reg_addr_t OFF_A_HI = 3'h4;
   localparam reg_addr_t OFF_B_LO = 3'h5;
   localparam reg_addr_t OFF_B_HI = 3'h6;

   // timer_control_reg bit positions
   localparam int CTRL_RUN_A  = 4;
   localparam int CTRL_FLAG_A = 5;
   localparam int CTRL_RUN_B  = 6;
   localparam int CTRL_FLAG_B = 7;

   // clock_rate_reg bit positions
   localparam int RATE_TURBO_A = 0;
   localparam int RATE_TURBO_B = 1;

   // reset values
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [3:0] RST_CFG   = 4'h0;

   // machine cycle timing: 12 clocks, phase 0 is state C1
   localparam logic [3:0] PH_LAST  = 4'hb;
   localparam logic [3:0] PH_C3    = 4'h2;
   localparam logic [3:0] PH_C4    = 4'h3;
   localparam logic [1:0] QTR_LAST = 2'h3;

endpackage

// [testbench/dual_timer_counter_four_mode_test.sv]
// self-checking bench for the dual timer/counter
`timescale 1ns/100ps

module dual_timer_counter_four_mode_test import timer_pkg::*; ;

   // one table case: preload, pin edges, expected count and flag
   typedef struct {
      logic       sel;
      tmode_t     mode;
      logic [7:0] hi;
      logic [7:0] lo;
      int         n;
      logic [7:0] ehi;
      logic [7:0] elo;
      logic       eflag;
   } row_t;

   logic       mclk;
   logic       reset;
   reg_addr_t  reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       count_input_a;
   logic       count_input_b;
   logic       ext_irq_pin_a;
   logic       ext_irq_pin_b;
   logic       vector_ack_a;
   logic       vector_ack_b;
   logic       timer_a_irq;
   logic       timer_b_irq;
   logic       baud_tick;
   int         n_errors;
   int         checks;
   int         cyc;
   int         baud_n;
   int         b0;
   row_t       r;
   timer_cfg_t cfg;
   logic [7:0] v;
   logic [7:0] v0;
   logic [7:0] run;

   // mode 0 upper low bits stay, mode 2 reloads, b in mode 3 holds
   row_t rows[6] = '{
      '{1'h0, MODE_13BIT,  8'hff, 8'hfe, 2, 8'h00, 8'he0, 1'h1},
      '{1'h0, MODE_16BIT,  8'hff, 8'hfe, 3, 8'h00, 8'h01, 1'h1},
      '{1'h0, MODE_RELOAD, 8'h80, 8'hfe, 3, 8'h80, 8'h81, 1'h1},
      '{1'h1, MODE_16BIT,  8'h00, 8'hff, 1, 8'h01, 8'h00, 1'h0},
      '{1'h1, MODE_RELOAD, 8'h05, 8'hff, 1, 8'h05, 8'h05, 1'h1},
      '{1'h1, MODE_SPLIT,  8'h12, 8'h34, 3, 8'h12, 8'h34, 1'h0}
   };

   dual_timer_counter dual_timer_counter_inst (
      .mclk          (mclk),
      .reset         (reset),
      .reg_addr      (reg_addr),
      .reg_wdata     (reg_wdata),
      .reg_wr        (reg_wr),
      .reg_rd        (reg_rd),
      .reg_rdata     (reg_rdata),
      .count_input_a (count_input_a),
      .count_input_b (count_input_b),
      .ext_irq_pin_a (ext_irq_pin_a),
      .ext_irq_pin_b (ext_irq_pin_b),
      .vector_ack_a  (vector_ack_a),
      .vector_ack_b  (vector_ack_b),
      .timer_a_irq   (timer_a_irq),
      .timer_b_irq   (timer_b_irq),
      .baud_tick     (baud_tick)
   );

   // 25 MHz clock
   initial begin
      mclk = 1'h0;
      forever #20 mclk = ~mclk;
   end

   // baud pulse tally and hang guard
   always @(posedge mclk) begin
      baud_n <= baud_n + int'(baud_tick);
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         n_errors++;
         close_out();
      end
   end

   task automatic close_out();
      if (n_errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
         n_errors++;
      end
   endtask

   // register bus: one-cycle strobes, read data sampled in the cycle after
   task automatic wr(input reg_addr_t a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge mclk);
      reg_wr <= 1'h0;
   endtask

   task automatic rd(input reg_addr_t a, output logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge mclk);
      reg_rd <= 1'h0;
      #1 d = reg_rdata;
   endtask

   // each pin level held 24 clocks, never faster than clock/24
   task automatic pulse(input logic sel, input int n);
      repeat (n) begin
         @(posedge mclk);
         if (sel) count_input_b <= 1'h1;
         else count_input_a <= 1'h1;
         repeat (24) @(posedge mclk);
         if (sel) count_input_b <= 1'h0;
         else count_input_a <= 1'h0;
         repeat (23) @(posedge mclk);
      end
      repeat (24) @(posedge mclk);
   endtask

   task automatic ack(input logic sel);
      @(posedge mclk);
      if (sel) vector_ack_b <= 1'h1;
      else vector_ack_a <= 1'h1;
      @(posedge mclk);
      vector_ack_a <= 1'h0;
      vector_ack_b <= 1'h0;
      #1 check({7'h0, sel ? timer_b_irq : timer_a_irq}, 8'h00);
   endtask

   // timer a low byte advance over exactly 120 clocks; settle first
   task automatic measure(input logic [7:0] exp);
      repeat (12) @(posedge mclk);
      rd(OFF_A_LO, v0);
      repeat (118) @(posedge mclk);
      rd(OFF_A_LO, v);
      check(v - v0, exp);
   endtask

   initial begin
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      {count_input_a, count_input_b, ext_irq_pin_a, ext_irq_pin_b} = 4'h0;
      {vector_ack_a, vector_ack_b, n_errors, checks, cyc, baud_n} = '0;
      reset = 1'h1;
      repeat (4) @(posedge mclk);
      reset <= 1'h0;
      // every register clears, unmapped offset reads 0 and ignores writes
      wr(3'h7, 8'hff);
      for (int i = 0; i < 8; i++) begin
         rd(reg_addr_t'(i), v);
         check(v, 8'h00);
      end
      // pin counting: timer a in modes 0 to 2, timer b in modes 1 to 3
      foreach (rows[i]) begin
         r = rows[i];
         cfg = '{gate: 1'h0, ext_count: 1'h1, mode: r.mode};
         run = r.sel ? 8'h40 : 8'h10;
         wr(r.sel ? OFF_B_LO : OFF_A_LO, r.lo);
         wr(r.sel ? OFF_B_HI : OFF_A_HI, r.hi);
         wr(OFF_MODE, r.sel ? {cfg, 4'h0} : {4'h0, cfg});
         wr(OFF_CTRL, run);
         pulse(r.sel, r.n);
         rd(r.sel ? OFF_B_LO : OFF_A_LO, v);
         check(v, r.elo);
         rd(r.sel ? OFF_B_HI : OFF_A_HI, v);
         check(v, r.ehi);
         rd(OFF_CTRL, v);
         check(v, run | (r.eflag ? run << 1 : 8'h00));
         check({7'h0, r.sel ? timer_b_irq : timer_a_irq}, {7'h0, r.eflag});
         if (r.eflag) ack(r.sel);
         wr(OFF_CTRL, 8'h00);
      end
      // gated clock counting, then turbo rate, then run off
      wr(OFF_MODE, 8'h09);
      wr(OFF_CTRL, 8'h10);
      measure(8'd0);
      @(posedge mclk);
      ext_irq_pin_a <= 1'h1;
      measure(8'd10);
      wr(OFF_RATE, 8'h01);
      measure(8'd30);
      wr(OFF_CTRL, 8'h00);
      measure(8'd0);
      wr(OFF_RATE, 8'h00);
      // split: a high byte on run_b sets flag_b, b reloads and feeds baud
      wr(OFF_A_HI, 8'hff);
      wr(OFF_A_LO, 8'h00);
      wr(OFF_B_HI, 8'hff);
      wr(OFF_B_LO, 8'hff);
      wr(OFF_MODE, 8'h23);
      wr(OFF_CTRL, 8'h40);
      repeat (30) @(posedge mclk);
      rd(OFF_CTRL, v);
      check(v, 8'hc0);
      rd(OFF_A_LO, v);
      check(v, 8'h00);
      check({7'h0, timer_b_irq}, 8'h01);
      ack(1'h1);
      // split low byte on run_a alone, high byte idle
      wr(OFF_CTRL, 8'h10);
      measure(8'd10);
      wr(OFF_CTRL, 8'h00);
      repeat (12) @(posedge mclk);
      b0 = baud_n;
      repeat (120) @(posedge mclk);
      check(8'(baud_n - b0), 8'd10);
      rd(OFF_CTRL, v);
      check(v, 8'h00);
      // mid-run reset with turbo, runs and flags set must clear them all
      wr(OFF_RATE, 8'h03);
      wr(OFF_CTRL, 8'hf0);
      @(posedge mclk);
      reset <= 1'h1;
      repeat (4) @(posedge mclk);
      reset <= 1'h0;
      for (int i = 0; i < 7; i++) begin
         rd(reg_addr_t'(i), v);
         check(v, 8'h00);
      end
      check({6'h0, timer_a_irq, timer_b_irq}, 8'h00);
      close_out();
   end

endmodule // dual_timer_counter_four_mode_test
